// ---- logic/qei_regs_top.sv ----
`timescale 1ns/100ps
// Behaviour
// - In processor idle, block runs when idle_stop is 0, halts when 1.
// - idle_stop clears to 0 on reset.
// - Timer mode keeps counting in idle unless idle_stop is set.
// - Events: rollover/underflow, qualified index, count error, period, gate.
// - Any event sets the single module interrupt flag; a count error only while its irq is not disabled.
// - Flag raises the interrupt only while its enable bit is set.
// - Control upper byte: error 15, idle 13, index 12, direction 11, mode.
// - Control lower byte: swap, gate, prescale, index reset, clock, dir src.
// - Filter control: match value, error irq disable, output enable, divide.
// - Mode 001 timer, 100/101 x2, 110/111 x4 with index or max reset.
// - Index modes flag count error at 0xFFFF or max+1; irq unless disabled.
// - Filter output and network are disabled by reset.
module qei_regs_top
    import qei_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    // Register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wr_data_i,
    input  wire logic              wr_en_i,
    input  wire logic              rd_en_i,
    output logic      [DATA_W-1:0] rd_data_o,
    // Encoder pins
    input  wire logic              phase_a_input_i,
    input  wire logic              phase_b_input_i,
    input  wire logic              index_pin_i,
    // System
    input  wire logic              cpu_idle_i,
    output logic                   irq_o,
    output logic                   count_direction_o,
    output logic      [8:0]        analog_pin_config_o
);

    function automatic logic [7:0] div_limit(input logic [2:0] sel);
        div_limit = 8'((9'h001 << sel) - 9'h001);
    endfunction

    function automatic logic is_idx_mode(input logic [2:0] m);
        is_idx_mode = (m == MODE_X2_IDX) || (m == MODE_X4_IDX);
    endfunction

    function automatic logic wr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] r,
                                    input logic              we);
        wr_hit = we && (a == r);
    endfunction

    logic [15:0] ctrl_reg;
    logic [15:0] filt_reg;
    logic [15:0] pos_reg;
    logic [15:0] max_reg;
    logic [15:0] ana_reg;
    logic [15:0] stat_reg;
    logic [15:0] mask_reg;
    logic [7:0]  fdiv_reg;
    logic [7:0]  pre_reg;
    logic [2:0]  h0_reg;
    logic [2:0]  h1_reg;
    logic [2:0]  h2_reg;
    logic [2:0]  pin_reg;
    logic        pa_reg;
    logic        pb_reg;
    logic        pi_reg;

    logic [2:0]  mode;
    logic        run;
    logic        ftick;
    logic        a;
    logic        b;
    logic        a_edge;
    logic        b_edge;
    logic        quad_up;
    logic        cnt_pulse;
    logic        idx_match;
    logic        idx_qual;
    logic        pre_tick;
    logic        tmr_tick;
    logic        tmr_up;
    logic        gate_ev;
    logic        cerr_hit;
    logic [15:0] pos_next;
    logic [4:0]  ev;

    assign mode = ctrl_reg[CTRL_MODE_H:CTRL_MODE_L];
    assign run  = !(cpu_idle_i && ctrl_reg[CTRL_IDLE]);

    // Filter clock divider and three-sample filter for index, B, A
    assign ftick = (fdiv_reg == div_limit(filt_reg[FILT_CK_H:FILT_CK_L]));

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            fdiv_reg <= 8'h00;
        end else if (run) begin
            fdiv_reg <= ftick ? 8'h00 : fdiv_reg + 8'h01;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            h0_reg  <= 3'h0;
            h1_reg  <= 3'h0;
            h2_reg  <= 3'h0;
            pin_reg <= 3'h0;
        end else if (run) begin
            if (!filt_reg[FILT_OUTEN]) begin
                pin_reg <= {index_pin_i, phase_b_input_i, phase_a_input_i};
            end else if (ftick) begin
                h0_reg <= {index_pin_i, phase_b_input_i, phase_a_input_i};
                h1_reg <= h0_reg;
                h2_reg <= h1_reg;
                for (int i = 0; i < 3; i++) begin
                    if (h0_reg[i] == h1_reg[i] && h1_reg[i] == h2_reg[i]) begin
                        pin_reg[i] <= h0_reg[i];
                    end
                end
            end
        end
    end

    // Phase decode
    assign a = ctrl_reg[CTRL_SWAP] ? pin_reg[1] : pin_reg[0];
    assign b = ctrl_reg[CTRL_SWAP] ? pin_reg[0] : pin_reg[1];

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pa_reg <= 1'b0;
            pb_reg <= 1'b0;
            pi_reg <= 1'b0;
        end else if (run) begin
            pa_reg <= a;
            pb_reg <= b;
            pi_reg <= pin_reg[2];
        end
    end

    assign a_edge    = run && (a != pa_reg);
    assign b_edge    = run && (b != pb_reg);
    assign quad_up   = a_edge ? (a != b) : (a == b);
    assign cnt_pulse = mode[2] && (a_edge || (mode[1] && b_edge));

    // Index qualification against the match value
    always_comb begin
        if (mode[1]) begin
            idx_match = (b == filt_reg[FILT_MATCH_H])
                     && (a == filt_reg[FILT_MATCH_L]);
        end else begin
            idx_match = ((filt_reg[FILT_MATCH_H] ? b : a)
                      == filt_reg[FILT_MATCH_L]);
        end
    end

    assign idx_qual = run && mode[2] && pin_reg[2] && !pi_reg && idx_match;

    // Timer prescaler and gate
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pre_reg <= 8'h00;
        end else if (run && mode == MODE_TIMER) begin
            pre_reg <= pre_tick ? 8'h00 : pre_reg + 8'h01;
        end
    end

    always_comb begin
        unique case (ctrl_reg[CTRL_PRE_H:CTRL_PRE_L])
            2'h0: pre_tick = 1'b1;
            2'h1: pre_tick = (pre_reg == 8'h07);
            2'h2: pre_tick = (pre_reg == 8'h3F);
            2'h3: pre_tick = (pre_reg == 8'hFF);
        endcase
    end

    always_comb begin
        tmr_tick = 1'b0;
        gate_ev  = 1'b0;
        if (run && mode == MODE_TIMER) begin
            if (ctrl_reg[CTRL_TCS]) begin
                tmr_tick = a && !pa_reg;
            end else if (ctrl_reg[CTRL_GATE]) begin
                tmr_tick = pre_tick && a;
                gate_ev  = !a && pa_reg;
            end else begin
                tmr_tick = pre_tick;
            end
        end
    end

    assign tmr_up = ctrl_reg[CTRL_DSRC] ? b : ctrl_reg[CTRL_DIR];

    // Counter next value and event collection
    always_comb begin
        pos_next = pos_reg;
        ev       = 5'h00;
        cerr_hit = 1'b0;
        if (tmr_tick) begin
            if (tmr_up) begin
                pos_next = (pos_reg == max_reg) ? 16'h0000 : pos_reg + 16'h1;
                ev[IRQ_PERIOD] = (pos_reg == max_reg);
            end else begin
                pos_next = (pos_reg == 16'h0000) ? max_reg : pos_reg - 16'h1;
                ev[IRQ_PERIOD] = (pos_reg == 16'h0000);
            end
        end else if (idx_qual && ctrl_reg[CTRL_IDXRST]
                     && is_idx_mode(mode)) begin
            pos_next = 16'h0000;
        end else if (cnt_pulse) begin
            if (quad_up) begin
                if (!is_idx_mode(mode) && pos_reg == max_reg) begin
                    pos_next      = 16'h0000;
                    ev[IRQ_ROLL]  = 1'b1;
                end else begin
                    pos_next = pos_reg + 16'h1;
                end
                cerr_hit = is_idx_mode(mode)
                        && (pos_next == max_reg + 16'h1);
            end else begin
                if (!is_idx_mode(mode) && pos_reg == 16'h0000) begin
                    pos_next      = max_reg;
                    ev[IRQ_ROLL]  = 1'b1;
                end else begin
                    pos_next = pos_reg - 16'h1;
                end
                cerr_hit = is_idx_mode(mode) && (pos_next == 16'hFFFF);
            end
        end
        ev[IRQ_INDEX] = idx_qual;
        ev[IRQ_CERR]  = cerr_hit && !filt_reg[FILT_CE_OFF];
        ev[IRQ_GATE]  = gate_ev;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pos_reg <= POS_RST;
        end else if (wr_hit(addr_i, ADDR_POS, wr_en_i)) begin
            pos_reg <= wr_data_i;
        end else begin
            pos_reg <= pos_next;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            max_reg <= MAX_RST;
            ana_reg <= ANA_RST;
        end else begin
            if (wr_hit(addr_i, ADDR_MAX, wr_en_i)) begin
                max_reg <= wr_data_i;
            end
            if (wr_hit(addr_i, ADDR_ANA, wr_en_i)) begin
                ana_reg <= wr_data_i & ANA_WMASK;
            end
        end
    end

    // Control register; hardware sets of the error flag win over writes
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctrl_reg <= CTRL_RST;
        end else begin
            if (wr_hit(addr_i, ADDR_CTRL, wr_en_i)) begin
                ctrl_reg <= wr_data_i & CTRL_WMASK;
            end
            if (cnt_pulse && mode[2]) begin
                ctrl_reg[CTRL_DIR] <= quad_up;
            end
            if (cerr_hit) begin
                ctrl_reg[CTRL_CERR] <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            filt_reg <= FILT_RST;
        end else if (wr_hit(addr_i, ADDR_FILT, wr_en_i)) begin
            filt_reg <= wr_data_i & FILT_WMASK;
        end
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            stat_reg <= IRQ_RST;
            mask_reg <= IRQ_RST;
        end else begin
            stat_reg <= (stat_reg
                        & ~(wr_hit(addr_i, ADDR_IRQ_STAT, wr_en_i)
                            ? wr_data_i & IRQ_WMASK : 16'h0000))
                        | {|ev, 10'h000, ev};
            if (wr_hit(addr_i, ADDR_IRQ_MASK, wr_en_i)) begin
                mask_reg <= wr_data_i & IRQ_WMASK;
            end
        end
    end

    assign irq_o               = |(stat_reg & mask_reg);
    assign count_direction_o   = ctrl_reg[CTRL_DIR];
    assign analog_pin_config_o = ana_reg[8:0];

    // Read data, one cycle after the strobe
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rd_data_o <= 16'h0000;
        end else if (rd_en_i) begin
            unique case (addr_i)
                ADDR_CTRL: rd_data_o <= (ctrl_reg & ~16'h1000)
                                        | {3'h0, pin_reg[2], 12'h000};
                ADDR_FILT:     rd_data_o <= filt_reg;
                ADDR_POS:      rd_data_o <= pos_reg;
                ADDR_MAX:      rd_data_o <= max_reg;
                ADDR_IRQ_STAT: rd_data_o <= stat_reg;
                ADDR_IRQ_MASK: rd_data_o <= mask_reg;
                ADDR_ANA:      rd_data_o <= ana_reg;
                default:       rd_data_o <= 16'h0000;
            endcase
        end else begin
            rd_data_o <= 16'h0000;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    chk_idle_halt: assert property (
        (!run && !wr_hit(addr_i, ADDR_POS, wr_en_i)) |=> $stable(pos_reg))
        else $error("count moved while halted in idle");
    chk_timer_idle: assert property (
        (cpu_idle_i && !ctrl_reg[CTRL_IDLE] && mode == MODE_TIMER
         && !ctrl_reg[CTRL_TCS] && !ctrl_reg[CTRL_GATE]
         && ctrl_reg[CTRL_PRE_H:CTRL_PRE_L] == 2'h0 && !ctrl_reg[CTRL_DSRC]
         && ctrl_reg[CTRL_DIR] && pos_reg != max_reg
         && !wr_hit(addr_i, ADDR_POS, wr_en_i))
        |=> pos_reg == $past(pos_reg) + 16'h1)
        else $error("timer did not count during idle");
    chk_reset_vals: assert property (
        $fell(rst_i) |-> (ctrl_reg == CTRL_RST && filt_reg == FILT_RST
                          && pos_reg == POS_RST && max_reg == MAX_RST))
        else $error("register reset value wrong");
    chk_event_flag: assert property (
        (|ev) |=> stat_reg[IRQ_FLAG] ##1 stat_reg[IRQ_FLAG] || $past(wr_en_i))
        else $error("event did not set the flag");
    chk_flag_sticky: assert property (
        (stat_reg[IRQ_FLAG] && !wr_hit(addr_i, ADDR_IRQ_STAT, wr_en_i))
        |=> stat_reg[IRQ_FLAG])
        else $error("flag cleared without software");
    chk_irq_enable: assert property (
        (stat_reg[IRQ_FLAG] && !mask_reg[IRQ_FLAG] && mask_reg[4:0] == 5'h00)
        |-> !irq_o)
        else $error("interrupt raised while disabled");
    chk_max_wrap: assert property (
        (mode == MODE_X4_MAX && cnt_pulse && quad_up && pos_reg == max_reg
         && !wr_hit(addr_i, ADDR_POS, wr_en_i))
        |=> pos_reg == 16'h0000 && stat_reg[IRQ_ROLL])
        else $error("maximum count reset failed");
    chk_count_error: assert property (
        cerr_hit |=> ctrl_reg[CTRL_CERR]
                     && (stat_reg[IRQ_CERR]
                         || $past(filt_reg[FILT_CE_OFF]))
                     && (!$past(filt_reg[FILT_CE_OFF])
                         || $past(stat_reg[IRQ_CERR])
                         || !stat_reg[IRQ_CERR]))
        else $error("count error handling wrong");
    chk_filt_read: assert property (
        (rd_en_i && addr_i == ADDR_FILT)
        |=> rd_data_o[15:11] == 5'h00 && rd_data_o[3:0] == 4'h0)
        else $error("reserved filter bits not zero");
    chk_ctrl_index: assert property (
        (rd_en_i && addr_i == ADDR_CTRL)
        |=> rd_data_o[CTRL_INDEX] == $past(pin_reg[2]) && !rd_data_o[14]
            && !rd_data_o[3])
        else $error("control read layout wrong");

    cov_index_reset: cover property (idx_qual && ctrl_reg[CTRL_IDXRST]);
    cov_timer_period: cover property (ev[IRQ_PERIOD]);
    cov_count_error: cover property (cerr_hit ##1 irq_o);
    cov_idle_halt: cover property (!run ##1 run);

endmodule

// ---- shared/qei_pkg.sv ----
package qei_pkg;
    // Register port
    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 16;
    localparam logic [11:0] ADDR_CTRL     = 12'h122;
    localparam logic [11:0] ADDR_FILT     = 12'h124;
    localparam logic [11:0] ADDR_POS      = 12'h126;
    localparam logic [11:0] ADDR_MAX      = 12'h128;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h12A;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h12C;
    localparam logic [11:0] ADDR_ANA      = 12'h2A8;

    // encoder_control fields
    localparam int CTRL_CERR   = 15;
    localparam int CTRL_IDLE   = 13;
    localparam int CTRL_INDEX  = 12;
    localparam int CTRL_DIR    = 11;
    localparam int CTRL_MODE_H = 10;
    localparam int CTRL_MODE_L = 8;
    localparam int CTRL_SWAP   = 7;
    localparam int CTRL_GATE   = 6;
    localparam int CTRL_PRE_H  = 5;
    localparam int CTRL_PRE_L  = 4;
    localparam int CTRL_IDXRST = 2;
    localparam int CTRL_TCS    = 1;
    localparam int CTRL_DSRC   = 0;

    // input_filter_control fields
    localparam int FILT_MATCH_H = 10;
    localparam int FILT_MATCH_L = 9;
    localparam int FILT_CE_OFF  = 8;
    localparam int FILT_OUTEN   = 7;
    localparam int FILT_CK_H    = 6;
    localparam int FILT_CK_L    = 4;

    // Interrupt status and mask layout
    localparam int IRQ_ROLL    = 0;
    localparam int IRQ_INDEX   = 1;
    localparam int IRQ_CERR    = 2;
    localparam int IRQ_PERIOD  = 3;
    localparam int IRQ_GATE    = 4;
    localparam int IRQ_FLAG    = 15;

    // Writable bits and reset values
    localparam logic [15:0] CTRL_WMASK = 16'hAFF7;
    localparam logic [15:0] FILT_WMASK = 16'h07F0;
    localparam logic [15:0] ANA_WMASK  = 16'h01FF;
    localparam logic [15:0] IRQ_WMASK  = 16'h801F;
    localparam logic [15:0] CTRL_RST   = 16'h0000;
    localparam logic [15:0] FILT_RST   = 16'h0000;
    localparam logic [15:0] POS_RST    = 16'h0000;
    localparam logic [15:0] MAX_RST    = 16'hFFFF;
    localparam logic [15:0] ANA_RST    = 16'h0000;
    localparam logic [15:0] IRQ_RST    = 16'h0000;

    // Mode field codes
    localparam logic [2:0] MODE_TIMER   = 3'h1;
    localparam logic [2:0] MODE_X2_IDX  = 3'h4;
    localparam logic [2:0] MODE_X2_MAX  = 3'h5;
    localparam logic [2:0] MODE_X4_IDX  = 3'h6;
    localparam logic [2:0] MODE_X4_MAX  = 3'h7;
endpackage

// ---- verif/qei_enc_model.sv ----
`timescale 1ns/100ps
module qei_enc_model (
    // Clock
    input  wire logic clk_i,
    // Step control from the bench
    input  wire logic step_i,
    input  wire logic dir_i,
    input  wire logic index_i,
    // Encoder pins
    output logic      phase_a_o,
    output logic      phase_b_o,
    output logic      index_o
);
    logic [1:0] st_reg;

    initial st_reg = 2'h0;

    always @(posedge clk_i) begin
        if (step_i) begin
            st_reg <= dir_i ? st_reg + 2'h1 : st_reg - 2'h1;
        end
    end

    // Gray sequence, one phase change per step, A leads B going up
    assign phase_a_o = st_reg[1] ^ st_reg[0];
    assign phase_b_o = st_reg[1];
    assign index_o   = index_i;
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/100ps
module tb_top
    import qei_pkg::*;
;
    logic              sys_clk;
    logic              rst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdat;
    logic              wen;
    logic              ren;
    logic [DATA_W-1:0] rdat;
    logic              pa;
    logic              pb;
    logic              idx;
    logic              cpu_idle;
    logic              irq;
    logic              dir_up;
    logic [8:0]        ana;
    logic              stp;
    logic              sdir;
    logic              sidx;
    int                fail_count;
    int                n_checks;
    int                cyc;
    int                seed;
    logic [15:0]       d0;
    logic [15:0]       d1;
    logic [11:0]       a;
    logic [11:0]       tbl [6];

    always #5 sys_clk = ~sys_clk;

    qei_regs_top u_qei_regs_top (
        .sys_clk_i          (sys_clk),
        .rst_i              (rst),
        .addr_i             (addr),
        .wr_data_i          (wdat),
        .wr_en_i            (wen),
        .rd_en_i            (ren),
        .rd_data_o          (rdat),
        .phase_a_input_i    (pa),
        .phase_b_input_i    (pb),
        .index_pin_i        (idx),
        .cpu_idle_i         (cpu_idle),
        .irq_o              (irq),
        .count_direction_o  (dir_up),
        .analog_pin_config_o(ana)
    );

    qei_enc_model u_qei_enc_model (
        .clk_i    (sys_clk),
        .step_i   (stp),
        .dir_i    (sdir),
        .index_i  (sidx),
        .phase_a_o(pa),
        .phase_b_o(pb),
        .index_o  (idx)
    );

    task test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [11:0] wa, input logic [15:0] wd);
        @(posedge sys_clk);
        wen  <= 1'b1;
        addr <= wa;
        wdat <= wd;
        @(posedge sys_clk);
        wen  <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe edge
    task rd(input logic [11:0] ra, output logic [15:0] rv);
        @(posedge sys_clk);
        ren  <= 1'b1;
        addr <= ra;
        @(posedge sys_clk);
        ren  <= 1'b0;
        @(negedge sys_clk);
        rv = rdat;
    endtask

    task rchk(input logic [11:0] ra, input logic [15:0] m,
              input logic [15:0] e);
        logic [15:0] v;
        rd(ra, v);
        chk(v & m, e);
    endtask

    task step(input logic up);
        @(posedge sys_clk);
        stp  <= 1'b1;
        sdir <= up;
        @(posedge sys_clk);
        stp  <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    task tend(input string name);
        $display("test %s done", name);
    endtask

    function automatic logic [15:0] wexp(input logic [11:0] wa,
                                         input logic [15:0] wd);
        case (wa)
            ADDR_CTRL: wexp = wd & 16'hA8F7;
            ADDR_FILT: wexp = wd & 16'h07F0;
            ADDR_POS:  wexp = wd;
            ADDR_MAX:  wexp = wd;
            ADDR_ANA:  wexp = wd & 16'h01FF;
            default:   wexp = 16'h0000;
        endcase
    endfunction

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
    end

    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        addr = 12'h000;
        wdat = 16'h0000;
        wen = 1'b0;
        ren = 1'b0;
        cpu_idle = 1'b0;
        stp = 1'b0;
        sdir = 1'b1;
        sidx = 1'b0;
        seed = 32'h4EFA;
        tbl = '{ADDR_CTRL, ADDR_FILT, ADDR_POS, ADDR_MAX, ADDR_ANA, 12'h130};
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        rchk(ADDR_CTRL, 16'hFFFF, 16'h0000);
        rchk(ADDR_FILT, 16'hFFFF, 16'h0000);
        rchk(ADDR_POS, 16'hFFFF, 16'h0000);
        rchk(ADDR_MAX, 16'hFFFF, 16'hFFFF);
        rchk(ADDR_ANA, 16'hFFFF, 16'h0000);
        rchk(ADDR_IRQ_STAT, 16'hFFFF, 16'h0000);
        tend("reset");
        // Random traffic over control, filter, position, maximum and analog registers and one unmapped place
        for (int i = 0; i < 24; i++) begin
            a = tbl[i % 6];
            d0 = 16'($random(seed));
            if (a == ADDR_CTRL) d0[10:8] = 3'h0;
            wr(a, d0);
            rd(a, d1);
            chk(d1, wexp(a, d0));
            if (a == ADDR_CTRL) chk({15'h0, dir_up}, {15'h0, d0[11]});
            if (a == ADDR_ANA) chk({7'h0, ana}, {7'h0, d0[8:0]});
        end
        tend("registers");
        // Random traffic may leave the filter on with a slow divide
        wr(ADDR_FILT, 16'h0000);
        wr(ADDR_MAX, 16'h0003);
        wr(ADDR_POS, 16'h0000);
        wr(ADDR_CTRL, 16'h0700);
        wr(ADDR_IRQ_STAT, 16'h801F);
        for (int i = 1; i <= 4; i++) begin
            step(1'b1);
            rchk(ADDR_POS, 16'hFFFF, 16'(i % 4));
        end
        chk({15'h0, dir_up}, 16'h0001);
        rchk(ADDR_IRQ_STAT, 16'hFFFF, 16'h8001);
        chk({15'h0, irq}, 16'h0000);
        wr(ADDR_IRQ_MASK, 16'h8000);
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({15'h0, irq}, 16'h0001);
        rchk(ADDR_IRQ_STAT, 16'hFFFF, 16'h8001);
        wr(ADDR_IRQ_STAT, 16'h8001);
        rchk(ADDR_IRQ_STAT, 16'hFFFF, 16'h0000);
        chk({15'h0, irq}, 16'h0000);
        step(1'b0);
        rchk(ADDR_POS, 16'hFFFF, 16'h0003);
        chk({15'h0, dir_up}, 16'h0000);
        rchk(ADDR_IRQ_STAT, 16'hFFFF, 16'h8001);
        step(1'b1);
        wr(ADDR_IRQ_STAT, 16'h801F);
        tend("x4 max");
        wr(ADDR_CTRL, 16'h2700);
        @(posedge sys_clk) cpu_idle <= 1'b1;
        step(1'b1);
        rchk(ADDR_POS, 16'hFFFF, 16'h0000);
        step(1'b0);
        wr(ADDR_CTRL, 16'h0700);
        step(1'b1);
        rchk(ADDR_POS, 16'hFFFF, 16'h0001);
        step(1'b0);
        wr(ADDR_MAX, 16'hFFFF);
        wr(ADDR_POS, 16'h0000);
        wr(ADDR_CTRL, 16'h2900);
        rd(ADDR_POS, d0);
        repeat (10) @(posedge sys_clk);
        rd(ADDR_POS, d1);
        chk(d1, d0);
        wr(ADDR_CTRL, 16'h0900);
        rd(ADDR_POS, d0);
        repeat (10) @(posedge sys_clk);
        rd(ADDR_POS, d1);
        chk({15'h0, d1 != d0}, 16'h0001);
        @(posedge sys_clk) cpu_idle <= 1'b0;
        wr(ADDR_MAX, 16'h0005);
        wr(ADDR_POS, 16'h0000);
        wr(ADDR_IRQ_STAT, 16'h801F);
        repeat (20) @(posedge sys_clk);
        rchk(ADDR_IRQ_STAT, 16'h8008, 16'h8008);
        tend("idle and timer");
        wr(ADDR_MAX, 16'hFFFF);
        wr(ADDR_CTRL, 16'h0940);
        wr(ADDR_IRQ_STAT, 16'h801F);
        repeat (3) step(1'b1);
        rchk(ADDR_IRQ_STAT, 16'h0010, 16'h0010);
        step(1'b1);
        tend("gate");
        wr(ADDR_MAX, 16'h0003);
        wr(ADDR_CTRL, 16'h0600);
        wr(ADDR_POS, 16'h0003);
        wr(ADDR_IRQ_STAT, 16'h801F);
        step(1'b1);
        rchk(ADDR_CTRL, 16'h8000, 16'h8000);
        rchk(ADDR_IRQ_STAT, 16'h8004, 16'h8004);
        wr(ADDR_POS, 16'h0000);
        wr(ADDR_CTRL, 16'h0600);
        wr(ADDR_FILT, 16'h0100);
        wr(ADDR_POS, 16'h0003);
        wr(ADDR_IRQ_STAT, 16'h801F);
        step(1'b1);
        rchk(ADDR_CTRL, 16'h8000, 16'h8000);
        rchk(ADDR_IRQ_STAT, 16'h0004, 16'h0000);
        tend("count error");
        // Phases now stand at A=1 B=1, matched by the index value
        wr(ADDR_POS, 16'h0000);
        wr(ADDR_FILT, 16'h0600);
        wr(ADDR_IRQ_STAT, 16'h801F);
        @(posedge sys_clk) sidx <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rchk(ADDR_CTRL, 16'h1000, 16'h1000);
        @(posedge sys_clk) sidx <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rchk(ADDR_IRQ_STAT, 16'h0002, 16'h0002);
        step(1'b1);
        step(1'b1);
        wr(ADDR_FILT, 16'h0000);
        wr(ADDR_MAX, 16'hFFFF);
        tend("index");
        for (int m = 4; m < 8; m++) begin
            wr(ADDR_CTRL, {5'h00, 3'(m), 8'h00});
            wr(ADDR_POS, 16'h0000);
            repeat (2) step(1'b1);
            rchk(ADDR_POS, 16'hFFFF, m[1] ? 16'h0002 : 16'h0001);
            repeat (2) step(1'b1);
            rchk(ADDR_POS, 16'hFFFF, m[1] ? 16'h0004 : 16'h0002);
        end
        tend("modes");
        test_done();
    end
endmodule
